// ### rtl/periodic_timer.sv
// periodic timer: run/mode control, counter, comparators, capture and output pin
//
// Function
// - run bit 1 counts; 0 stops, powers down
// - run rise zeroes counter; fall holds value
// - compare mode: run rise restores initial level
// - mode field: compare, capture, PWM/pulse, timer
// - timer/counter mode: pin undriven, level bits ignored
// - compare A match: none, low, high, toggle
// - PWM: inactive, active, PWM, single pulse
// - capture edge: rise, fall, both, disabled
// - match to same level shows no change
// - level bit: initial level or active level
// - invert bit inverts output pin level
// - capture source: capture pin or clock pin
// - clear source: A match, else P/overflow
// - overflow clear only when P is zero
// - clear source ignored in PWM, pulse, capture
// - compare mode, clear on P: both flags
// - clear on A: P flag never set
// - only A match or run rise changes pin in compare
// - counter maxima 0x3FF or 0xFFFF
// - pause freezes counter, module stays powered
// - clock select: sys/4, sys, high, sub, pin
`timescale 1ns/1ps

module periodic_timer
	import ptimer_pkg::*;
#(
	parameter int CNT_W = 10
) (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// counter clock sources
	input wire logic highClkTick,
	input wire logic subClkTick,
	// pins
	input wire logic extClockPin,
	input wire logic captureInputPin,
	output logic timerOutputPin,
	output logic timerOutputOe
);

	localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

	function automatic logic edgeHit(input logic prev, input logic cur, input logic rise);
		edgeHit = rise ? (cur & ~prev) : (~cur & prev);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: one wait-free data phase, reads registered at address phase

	dphase_e dpState;
	logic [7:0] dpAddr;
	logic addrPhase;
	logic wrEn;
	logic [31:0] rdMux;

	logic [7:0] runCtrl;
	logic [7:0] modeCtrl;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] compare_a_value;
	logic [CNT_W-1:0] compare_p_value;
	logic flagA;
	logic flagP;

	assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	assign wrEn = ce && dpState == DP_WRITE;
	// the bus stalls while the block is frozen, so no transfer is lost
	assign hreadyout = ce;
	assign hresp = HRESP_OKAY;

	always_comb begin
		case (haddr[7:0])
			RUN_CTRL_OFS: rdMux = {24'h000000, runCtrl};
			MODE_CTRL_OFS: rdMux = {24'h000000, modeCtrl};
			COUNT_OFS: rdMux = 32'(cnt);
			CMPA_OFS: rdMux = 32'(compare_a_value);
			CMPP_OFS: rdMux = 32'(compare_p_value);
			FLAG_OFS: rdMux = {30'h00000000, flagP, flagA};
			default: rdMux = 32'h00000000;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dpState <= DP_IDLE;
			dpAddr <= 8'h00;
		end else if (ce && hready) begin
			dpAddr <= haddr[7:0];
			if (addrPhase) begin
				dpState <= hwrite ? DP_WRITE : DP_READ;
			end else begin
				dpState <= DP_IDLE;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			hrdata <= 32'h00000000;
		end else if (ce && addrPhase && !hwrite) begin
			hrdata <= rdMux;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control fields

	logic pause;
	logic [2:0] clkSel;
	logic run;
	logic [1:0] mode;
	logic [1:0] pinFn;
	logic oc;
	logic inv;
	logic capSel;
	logic clrSel;
	logic runPrev;
	logic runRise;
	logic pulseMode;

	assign pause = runCtrl[PAUSE_BIT];
	assign clkSel = runCtrl[CLKSEL_HI:CLKSEL_LO];
	assign run = runCtrl[RUN_BIT];
	assign mode = modeCtrl[MODE_HI:MODE_LO];
	assign pinFn = modeCtrl[PINFN_HI:PINFN_LO];
	assign oc = modeCtrl[OLVL_BIT];
	assign inv = modeCtrl[INV_BIT];
	assign capSel = modeCtrl[CAPSRC_BIT];
	assign clrSel = modeCtrl[CLRSRC_BIT];
	assign runRise = ce && run && !runPrev;
	assign pulseMode = mode == MODE_PWM && pinFn == PF_PULSE;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			modeCtrl <= MODE_CTRL_RST;
		end else if (wrEn && dpAddr == MODE_CTRL_OFS) begin
			modeCtrl <= hwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin edges and counter clock selection

	logic extPrev;
	logic capPrev;
	logic extRise;
	logic [1:0] sysDiv;
	logic [5:0] hiDiv;
	logic srcTick;
	logic tick;

	assign extRise = edgeHit(extPrev, extClockPin, 1'b1);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			extPrev <= 1'b0;
			capPrev <= 1'b0;
			runPrev <= 1'b0;
		end else if (ce) begin
			extPrev <= extClockPin;
			capPrev <= captureInputPin;
			runPrev <= run;
		end
	end

	// prescalers sit at zero while off, which is the power-down state
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sysDiv <= 2'h0;
			hiDiv <= 6'h00;
		end else if (ce) begin
			if (!run) begin
				sysDiv <= 2'h0;
				hiDiv <= 6'h00;
			end else begin
				sysDiv <= sysDiv + 2'h1;
				if (highClkTick) begin
					hiDiv <= hiDiv + 6'h01;
				end
			end
		end
	end

	always_comb begin
		case (clkSel)
			CK_SYS4: srcTick = sysDiv == SYS_DIV_LAST;
			CK_SYS: srcTick = 1'b1;
			CK_HI16: srcTick = highClkTick && hiDiv[3:0] == HI16_LAST;
			CK_HI64: srcTick = highClkTick && hiDiv == HI64_LAST;
			CK_SUB0, CK_SUB1: srcTick = subClkTick;
			CK_EXTR: srcTick = extRise;
			CK_EXTF: srcTick = edgeHit(extPrev, extClockPin, 1'b0);
			default: srcTick = 1'b0;
		endcase
	end

	assign tick = ce && run && !pause && srcTick;

	////////////////////////////////////////////////////////////////////////////////
	// comparators and counter

	logic [CNT_W-1:0] inc;
	logic aHit;
	logic pHit;
	logic clrNow;
	logic capEdge;
	logic capEvt;
	logic evtA;
	logic evtP;

	assign inc = cnt + {{(CNT_W-1){1'b0}}, 1'b1};
	assign aHit = tick && inc == compare_a_value;
	// with P at zero the counter runs to its maximum and wraps
	assign pHit = tick && ((compare_p_value == '0) ? cnt == CNT_MAX : inc == compare_p_value);

	always_comb begin
		case (mode)
			MODE_CMP, MODE_TC: clrNow = clrSel ? aHit : pHit;
			MODE_PWM: clrNow = !pulseMode && pHit;
			MODE_CAP: clrNow = pHit;
			default: clrNow = 1'b0;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt <= '0;
		end else if (runRise) begin
			cnt <= '0;
		end else if (tick) begin
			cnt <= clrNow ? '0 : inc;
		end
	end

	logic capCur;
	logic capOld;

	assign capCur = capSel ? extClockPin : captureInputPin;
	assign capOld = capSel ? extPrev : capPrev;

	always_comb begin
		case (pinFn)
			CAP_RISE: capEdge = edgeHit(capOld, capCur, 1'b1);
			CAP_FALL: capEdge = edgeHit(capOld, capCur, 1'b0);
			CAP_BOTH: capEdge = capCur != capOld;
			default: capEdge = 1'b0;
		endcase
	end

	assign capEvt = ce && run && mode == MODE_CAP && capEdge;
	assign evtA = (mode == MODE_CAP) ? capEvt : aHit;
	assign evtP = pHit && !pulseMode && !((mode == MODE_CMP || mode == MODE_TC) && clrSel);

	// capture overrides a software write landing in the same cycle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			compare_a_value <= '0;
			compare_p_value <= '0;
		end else begin
			if (wrEn && dpAddr == CMPA_OFS) begin
				compare_a_value <= hwdata[CNT_W-1:0];
			end
			if (capEvt) begin
				compare_a_value <= cnt;
			end
			if (wrEn && dpAddr == CMPP_OFS) begin
				compare_p_value <= hwdata[CNT_W-1:0];
			end
		end
	end

	// write one clears; a set in the same cycle wins
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			flagA <= 1'b0;
			flagP <= 1'b0;
		end else begin
			if (wrEn && dpAddr == FLAG_OFS && hwdata[FLAG_A_BIT]) begin
				flagA <= 1'b0;
			end
			if (wrEn && dpAddr == FLAG_OFS && hwdata[FLAG_P_BIT]) begin
				flagP <= 1'b0;
			end
			if (evtA) begin
				flagA <= 1'b1;
			end
			if (evtP) begin
				flagP <= 1'b1;
			end
		end
	end

	// software write, then the single-pulse stop, then the pin start, so a set wins
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			runCtrl <= RUN_CTRL_RST;
		end else begin
			if (wrEn && dpAddr == RUN_CTRL_OFS) begin
				runCtrl <= hwdata[7:0] & RUN_CTRL_WMASK;
			end
			if (pulseMode && aHit) begin
				runCtrl[RUN_BIT] <= 1'b0;
			end
			if (ce && pulseMode && !run && extRise) begin
				runCtrl[RUN_BIT] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// output level and pin

	logic outLevel;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			outLevel <= 1'b0;
		end else if (ce) begin
			case (mode)
				MODE_CMP: begin
					if (runRise) begin
						outLevel <= oc;
					end else if (aHit) begin
						case (pinFn)
							PF_LOW: outLevel <= 1'b0;
							PF_HIGH: outLevel <= 1'b1;
							PF_TOGGLE: outLevel <= ~outLevel;
							default: outLevel <= outLevel;
						endcase
					end
				end
				MODE_PWM: begin
					case (pinFn)
						PF_INACT: outLevel <= ~oc;
						PF_ACT: outLevel <= oc;
						PF_PWM: outLevel <= (run && cnt < compare_a_value) ? oc : ~oc;
						default: outLevel <= run ? oc : ~oc;
					endcase
				end
				default: outLevel <= outLevel;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			timerOutputPin <= 1'b0;
			timerOutputOe <= 1'b0;
		end else if (ce) begin
			timerOutputPin <= outLevel ^ inv;
			timerOutputOe <= mode == MODE_CMP || mode == MODE_PWM;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	a_run_rise_zero: assert property (@(posedge mclk) disable iff (!rstn)
		runRise |=> cnt == '0) else $error("counter not zero after run rise");
	a_stop_holds: assert property (@(posedge mclk) disable iff (!rstn)
		!run |=> cnt == $past(cnt)) else $error("counter moved while stopped");
	a_pause_holds: assert property (@(posedge mclk) disable iff (!rstn)
		pause && !runRise |=> cnt == $past(cnt)) else $error("counter moved while paused");
	a_cmp_init_level: assert property (@(posedge mclk) disable iff (!rstn)
		runRise && mode == MODE_CMP |=> outLevel == $past(oc))
		else $error("initial level not restored on run rise");
	a_timer_no_drive: assert property (@(posedge mclk) disable iff (!rstn)
		ce && mode == MODE_TC |=> !timerOutputOe) else $error("pin driven in timer/counter mode");
	a_pin_invert: assert property (@(posedge mclk) disable iff (!rstn)
		ce |=> timerOutputPin == ($past(outLevel) ^ $past(inv))) else $error("pin polarity wrong");
	a_a_clears: assert property (@(posedge mclk) disable iff (!rstn)
		aHit && mode == MODE_CMP && clrSel && !runRise |=> cnt == '0)
		else $error("A match did not clear counter");
	a_overflow_wrap: assert property (@(posedge mclk) disable iff (!rstn)
		tick && !runRise && mode == MODE_TC && !clrSel && compare_p_value == '0 && cnt == CNT_MAX
		|=> cnt == '0 ##0 flagP) else $error("overflow did not wrap with P flag");
	a_no_p_flag: assert property (@(posedge mclk) disable iff (!rstn)
		mode == MODE_CMP && clrSel && !flagP |=> !flagP) else $error("P flag set with clear on A");
	a_a_flag_sets: assert property (@(posedge mclk) disable iff (!rstn)
		aHit && mode == MODE_CMP |=> flagA) else $error("A flag missing after match");
	a_pin_only_a: assert property (@(posedge mclk) disable iff (!rstn)
		mode == MODE_CMP && !runRise && !aHit |=> outLevel == $past(outLevel))
		else $error("pin changed without A match");

endmodule

// ### rtl/ptimer_pkg.sv
// constants shared by the periodic timer control and compare-output logic
package ptimer_pkg;

	// register byte offsets on the AHB-Lite slave
	localparam logic [7:0] RUN_CTRL_OFS = 8'h00;
	localparam logic [7:0] MODE_CTRL_OFS = 8'h04;
	localparam logic [7:0] COUNT_OFS = 8'h08;
	localparam logic [7:0] CMPA_OFS = 8'h0C;
	localparam logic [7:0] CMPP_OFS = 8'h10;
	localparam logic [7:0] FLAG_OFS = 8'h14;

	// reset values and the run control write mask
	localparam logic [7:0] RUN_CTRL_RST = 8'h00;
	localparam logic [7:0] MODE_CTRL_RST = 8'h00;
	localparam logic [7:0] RUN_CTRL_WMASK = 8'hF8;

	// timer_run_control fields
	localparam int PAUSE_BIT = 7;
	localparam int CLKSEL_HI = 6;
	localparam int CLKSEL_LO = 4;
	localparam int RUN_BIT = 3;

	// timer_mode_control fields
	localparam int MODE_HI = 7;
	localparam int MODE_LO = 6;
	localparam int PINFN_HI = 5;
	localparam int PINFN_LO = 4;
	localparam int OLVL_BIT = 3;
	localparam int INV_BIT = 2;
	localparam int CAPSRC_BIT = 1;
	localparam int CLRSRC_BIT = 0;

	// flag register fields
	localparam int FLAG_A_BIT = 0;
	localparam int FLAG_P_BIT = 1;

	// op_mode_select codes
	localparam logic [1:0] MODE_CMP = 2'h0;
	localparam logic [1:0] MODE_CAP = 2'h1;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TC = 2'h3;

	// pin_function_select codes per mode
	localparam logic [1:0] PF_NONE = 2'h0;
	localparam logic [1:0] PF_LOW = 2'h1;
	localparam logic [1:0] PF_HIGH = 2'h2;
	localparam logic [1:0] PF_TOGGLE = 2'h3;
	localparam logic [1:0] PF_INACT = 2'h0;
	localparam logic [1:0] PF_ACT = 2'h1;
	localparam logic [1:0] PF_PWM = 2'h2;
	localparam logic [1:0] PF_PULSE = 2'h3;
	localparam logic [1:0] CAP_RISE = 2'h0;
	localparam logic [1:0] CAP_FALL = 2'h1;
	localparam logic [1:0] CAP_BOTH = 2'h2;

	// clock_source_select codes
	localparam logic [2:0] CK_SYS4 = 3'h0;
	localparam logic [2:0] CK_SYS = 3'h1;
	localparam logic [2:0] CK_HI16 = 3'h2;
	localparam logic [2:0] CK_HI64 = 3'h3;
	localparam logic [2:0] CK_SUB0 = 3'h4;
	localparam logic [2:0] CK_SUB1 = 3'h5;
	localparam logic [2:0] CK_EXTR = 3'h6;
	localparam logic [2:0] CK_EXTF = 3'h7;

	// prescaler terminal counts
	localparam logic [1:0] SYS_DIV_LAST = 2'h3;
	localparam logic [3:0] HI16_LAST = 4'hF;
	localparam logic [5:0] HI64_LAST = 6'h3F;

	// AHB-Lite
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [1:0] {DP_IDLE, DP_READ, DP_WRITE} dphase_e;

endpackage

// ### bench/pin_model.sv
// far-side model: counter clock ticks and the timer's input pins
`timescale 1ns/1ps

module pin_model (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// counter clock sources
	output logic highClkTick,
	output logic subClkTick,
	// pins
	output logic extClockPin,
	output logic captureInputPin
);
	logic [3:0] div;
	logic [1:0] drv = 2'h0;

	////////////////////////////////////////////////////////////////
	// free-running ticks keep the prescaled sources busy
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			div <= 4'h0;
		else
			div <= div + 4'h1;
	end
	assign highClkTick = div[1:0] == 2'h3;
	assign subClkTick = div == 4'hF;
	assign extClockPin = drv[0];
	assign captureInputPin = drv[1];

	////////////////////////////////////////////////////////////////
	// each level holds two cycles so the edge detector never misses one
	task pulse(input int k, input int n);
		repeat (n) begin
			@(posedge mclk);
			drv[k] <= 1'b1;
			repeat (2) @(posedge mclk);
			drv[k] <= 1'b0;
			@(posedge mclk);
		end
		repeat (2) @(posedge mclk);
	endtask
endmodule

// ### bench/periodic_timer_tb_top.sv
// self-checking bench: AHB-Lite master, pin checks, result queue
`timescale 1ns/1ps

module periodic_timer_tb_top
	import ptimer_pkg::*;
;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic ce = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, highClkTick, subClkTick, extClockPin, captureInputPin;
	logic timerOutputPin, timerOutputOe;
	logic dataRd = 1'b0;
	logic pinReq = 1'b0;
	logic [31:0] expQ[$];
	string nameQ[$];
	logic [31:0] got, exp, a;
	string nm;
	int errorCnt = 0;
	int checked = 0;
	int i;

	periodic_timer #(.CNT_W(10)) periodic_timer_inst (
		.mclk(mclk), .rstn(rstn), .ce(ce), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.highClkTick(highClkTick), .subClkTick(subClkTick), .extClockPin(extClockPin),
		.captureInputPin(captureInputPin), .timerOutputPin(timerOutputPin),
		.timerOutputOe(timerOutputOe)
	);

	pin_model pin_model_inst (
		.mclk(mclk), .rstn(rstn), .highClkTick(highClkTick), .subClkTick(subClkTick),
		.extClockPin(extClockPin), .captureInputPin(captureInputPin)
	);

	initial begin
		forever #5 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////
	// result watcher: the oldest note is compared with what appears
	always @(posedge mclk) begin
		if ((dataRd && hreadyout === 1'b1) || pinReq) begin
			got = dataRd ? hrdata : {30'h0, timerOutputOe, timerOutputPin & timerOutputOe};
			exp = expQ.pop_front();
			nm = nameQ.pop_front();
			checked++;
			if (got !== exp) begin
				$display("Error %s: expected %h, seen %h", nm, exp, got);
				errorCnt++;
			end
			if (dataRd && hresp !== HRESP_OKAY) begin
				$display("Error hresp: expected %h, seen %h", HRESP_OKAY, hresp);
				errorCnt++;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	task giveVerdict();
		$display("comparisons %0d, mismatches %0d", checked, errorCnt);
		if (errorCnt == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task wait_ready();
		int n;
		n = 0;
		@(posedge mclk);
		while (hreadyout !== 1'b1) begin
			@(posedge mclk);
			n++;
			if (n > 50) begin
				errorCnt++;
				giveVerdict();
			end
		end
	endtask

	// address phase held until hready, then data phase until hready again
	task bus(input logic w, input logic [7:0] ad, input logic [31:0] d, input string s);
		haddr <= {24'h0, ad};
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= w ? d : 32'h0;
		dataRd <= !w;
		if (!w) begin
			expQ.push_back(d);
			nameQ.push_back(s);
		end
		wait_ready();
		dataRd <= 1'b0;
	endtask

	task wr(input logic [7:0] ad, input logic [31:0] d);
		bus(1'b1, ad, d, "");
	endtask

	task rd(input logic [7:0] ad, input logic [31:0] e, input string s);
		bus(1'b0, ad, e, s);
	endtask

	task chk_pin(input logic [1:0] e);
		expQ.push_back({30'h0, e});
		nameQ.push_back("pin");
		pinReq <= 1'b1;
		@(posedge mclk);
		pinReq <= 1'b0;
		@(posedge mclk);
	endtask

	function automatic logic [31:0] mc(input logic [1:0] m, input logic [1:0] pf,
		input logic [3:0] lo);
		return {24'h0, m, pf, lo};
	endfunction

	// mode is only changed while stopped; counter ticks come from pin rises
	task setup(input logic [31:0] mode);
		wr(RUN_CTRL_OFS, 32'h60);
		wr(MODE_CTRL_OFS, mode);
		wr(RUN_CTRL_OFS, 32'h68);
		repeat (4) @(posedge mclk);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(80));
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		for (i = 0; i < 7; i++)
			rd(8'(i * 4), 32'h0, "reset value");
		wr(MODE_CTRL_OFS, 32'hA5);
		rd(MODE_CTRL_OFS, 32'hA5, "mode reg");
		wr(RUN_CTRL_OFS, 32'hFF);
		rd(RUN_CTRL_OFS, 32'hF8, "run reg");
		wr(RUN_CTRL_OFS, 32'h0);
		$display("test registers done");

		a = 32'(2 + $urandom % 6);
		wr(CMPA_OFS, a);
		wr(CMPP_OFS, 32'h1);
		setup(mc(MODE_CMP, PF_TOGGLE, 4'h1));
		chk_pin(2'h2);
		pin_model_inst.pulse(0, 3 * a);
		chk_pin(2'h3);
		rd(COUNT_OFS, 32'h0, "count");
		rd(FLAG_OFS, 32'h1, "flags");
		wr(FLAG_OFS, 32'h3);
		rd(FLAG_OFS, 32'h0, "flags");
		setup(mc(MODE_CMP, PF_TOGGLE, 4'h1));
		chk_pin(2'h2);
		$display("test toggle done");

		wr(CMPA_OFS, 32'h2);
		wr(CMPP_OFS, 32'h5);
		setup(mc(MODE_CMP, PF_TOGGLE, 4'h0));
		pin_model_inst.pulse(0, 5);
		chk_pin(2'h3);
		rd(COUNT_OFS, 32'h0, "count");
		rd(FLAG_OFS, 32'h3, "flags");
		wr(FLAG_OFS, 32'h3);
		setup(mc(MODE_CMP, PF_HIGH, 4'hD));
		chk_pin(2'h2);
		pin_model_inst.pulse(0, 2);
		chk_pin(2'h2);
		rd(FLAG_OFS, 32'h1, "flags");
		wr(FLAG_OFS, 32'h3);
		$display("test compare done");

		wr(CMPA_OFS, 32'h3F0);
		wr(CMPP_OFS, 32'h0);
		setup(mc(MODE_TC, PF_TOGGLE, 4'h8));
		chk_pin(2'h0);
		pin_model_inst.pulse(0, 3);
		rd(COUNT_OFS, 32'h3, "count");
		wr(RUN_CTRL_OFS, 32'hE8);
		pin_model_inst.pulse(0, 2);
		rd(COUNT_OFS, 32'h3, "count");
		wr(RUN_CTRL_OFS, 32'h68);
		pin_model_inst.pulse(0, 1);
		rd(COUNT_OFS, 32'h4, "count");
		wr(RUN_CTRL_OFS, 32'h60);
		pin_model_inst.pulse(0, 2);
		rd(COUNT_OFS, 32'h4, "count");
		wr(RUN_CTRL_OFS, 32'h68);
		repeat (4) @(posedge mclk);
		rd(COUNT_OFS, 32'h0, "count");
		pin_model_inst.pulse(0, 1023);
		rd(COUNT_OFS, 32'h3FF, "count");
		pin_model_inst.pulse(0, 1);
		rd(COUNT_OFS, 32'h0, "count");
		rd(FLAG_OFS, 32'h3, "flags");
		wr(FLAG_OFS, 32'h3);
		$display("test timer done");

		// edge codes 0..3 from the capture pin, then the other source ignores it
		for (i = 0; i < 5; i++) begin
			wr(CMPA_OFS, 32'h55);
			wr(FLAG_OFS, 32'h3);
			setup(mc(MODE_CAP, 2'(i % 4), 4'(i / 4 * 2)));
			if (i < 4)
				pin_model_inst.pulse(0, 2);
			pin_model_inst.pulse(1, 1);
			rd(CMPA_OFS, (i > 2) ? 32'h55 : 32'h2, "capture");
			rd(FLAG_OFS, (i > 2) ? 32'h0 : 32'h1, "flags");
		end
		$display("test capture done");

		wr(CMPA_OFS, 32'h2);
		wr(CMPP_OFS, 32'h4);
		for (i = 0; i < 3; i++) begin
			setup(mc(MODE_PWM, 2'(i), 4'h8));
			chk_pin({1'b1, i != 0});
		end
		pin_model_inst.pulse(0, 2);
		chk_pin(2'h2);
		$display("test pwm done");
		repeat (2) @(posedge mclk);
		giveVerdict();
	end
endmodule
